// File: rtl/xic_map.svh
// register map, field positions, reset values and timing counts
`ifndef XIC_MAP_SVH
`define XIC_MAP_SVH
`define XIC_IDX_SYNC        8'h01
`define XIC_IDX_NONMASKABLE_CONTROL     8'h02
`define XIC_IDX_NMIPEND     8'h03
`define XIC_IDX_EVEN        8'h04
`define XIC_IDX_ENCLR       8'h08
`define XIC_IDX_ENSET       8'h0C
`define XIC_IDX_FLAGS       8'h10
`define XIC_IDX_CFG0        8'h18
`define XIC_IDX_CFG1        8'h1C
`define XIC_SYNC_BIT        7
`define XIC_NMI_FILT_BIT    3
`define XIC_NMI_PEND_BIT    0
`define XIC_RST_BYTE        8'h00
`define XIC_RST_WORD        32'h0000_0000
`define XIC_SYNC_CYCLES     3'h3
`define XIC_CFG_FIELD       4
`define XIC_SENSE_W         3
`define XIC_LINES_PER_CFG   8
`endif

// File: rtl/xic_pkg.sv
// shared types of the interrupt control block
package xic_pkg;
  typedef enum logic [2:0] {
    XIC_NONE, XIC_RISE, XIC_FALL, XIC_BOTH, XIC_HIGH, XIC_LOW
  } xic_sense_t;
endpackage

// File: rtl/xic_detect.sv
// one input conditioner: synchroniser, glitch filter and trigger detection
`include "xic_map.svh"
module xic_detect
  import xic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       pin,
  input  wire logic       filt_en,
  input  wire logic [2:0] sense,
  output logic            detect_reg
);
  logic       sync1_reg;
  logic       sync2_reg;
  logic [2:0] hist_reg;
  logic       prev_reg;
  logic       filt;
  logic       sel;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // majority of three samples rejects single-cycle glitches
  always_ff @(posedge clk) begin
    if (!rst_n) hist_reg <= 3'h0;
    else        hist_reg <= {hist_reg[1:0], sync2_reg};
  end

  assign filt = (hist_reg[0] & hist_reg[1]) | (hist_reg[1] & hist_reg[2]) |
                (hist_reg[0] & hist_reg[2]);
  assign sel  = filt_en ? filt : sync2_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) prev_reg <= 1'b0;
    else        prev_reg <= sel;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      detect_reg <= 1'b0;
    end else begin
      case (sense)
        XIC_RISE: detect_reg <= sel & ~prev_reg;
        XIC_FALL: detect_reg <= ~sel & prev_reg;
        XIC_BOTH: detect_reg <= sel ^ prev_reg;
        XIC_HIGH: detect_reg <= sel;
        XIC_LOW:  detect_reg <= ~sel;
        default:  detect_reg <= 1'b0;
      endcase
    end
  end

  AST_FILT_BYPASS: assert property (@(posedge clk) disable iff (!rst_n)
    (!filt_en && sense == XIC_HIGH && sync2_reg) |=> detect_reg)
    else $error("bypassed high level not detected");
  AST_SENSE_RISE: assert property (@(posedge clk) disable iff (!rst_n)
    (sense == XIC_RISE && !filt_en && sync2_reg && !prev_reg) |=> detect_reg)
    else $error("rising edge not detected");
  AST_SENSE_RSV: assert property (@(posedge clk) disable iff (!rst_n)
    (sense[2:1] == 2'b11) |=> !detect_reg)
    else $error("reserved sense code detected");
endmodule // xic_detect

// File: rtl/xic_ctrl.sv
// interrupt control registers: nonmaskable input, line enables, events
//
// Our own choice: the plain strobed port.
`include "xic_map.svh"
module xic_ctrl
  import xic_pkg::*;
#(
  parameter int LINES = 16
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [7:0]       bus_addr,
  input  wire logic [31:0]      bus_wdata,
  input  wire logic             bus_wr,
  input  wire logic             bus_rd,
  output logic      [31:0]      bus_rdata,
  input  wire logic             nonmaskable_pin,
  input  wire logic [LINES-1:0] ext_line_pin,
  output logic      [LINES-1:0] line_event,
  output logic                  nmi_irq,
  output logic                  line_irq
);
  // registers sit at their own byte offsets; each access moves a whole register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic [7:0]       nonmaskable_control_reg;
  logic [7:0]       nmi_active_reg;
  logic             sync_pending_reg;
  logic             sync_again_reg;
  logic [2:0]       sync_cnt_reg;
  logic             nonmaskable_pending_reg;
  logic [LINES-1:0] line_event_enable_reg;
  logic [LINES-1:0] ext_line_irq_en_reg;
  logic [LINES-1:0] line_pending_flags_reg;
  logic [31:0]      line_cfg_reg [2];
  logic [LINES-1:0] line_event_reg;
  logic             nmi_irq_reg;
  logic             line_irq_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic             nmi_det;
  logic [LINES-1:0] line_det;
  logic             wr_nonmaskable_control;
  logic             sync_done;

  assign wr_nonmaskable_control = bus_wr && hit(bus_addr, `XIC_IDX_NONMASKABLE_CONTROL);
  assign sync_done  = sync_pending_reg && (sync_cnt_reg == `XIC_SYNC_CYCLES);

  xic_detect u_nmi_det (
    .clk        (clk),
    .rst_n      (rst_n),
    .pin        (nonmaskable_pin),
    .filt_en    (nmi_active_reg[`XIC_NMI_FILT_BIT]),
    .sense      (nmi_active_reg[`XIC_SENSE_W-1:0]),
    .detect_reg (nmi_det)
  );

  for (genvar i = 0; i < LINES; i++) begin : g_line
    localparam int CW = i / `XIC_LINES_PER_CFG;
    localparam int LB = (i % `XIC_LINES_PER_CFG) * `XIC_CFG_FIELD;
    xic_detect u_det (
      .clk        (clk),
      .rst_n      (rst_n),
      .pin        (ext_line_pin[i]),
      .filt_en    (line_cfg_reg[CW][LB+`XIC_SENSE_W]),
      .sense      (line_cfg_reg[CW][LB +: `XIC_SENSE_W]),
      .detect_reg (line_det[i])
    );
  end

  // control value reads back at once; the detector sees it after transfer
  always_ff @(posedge clk) begin
    if (!rst_n) nonmaskable_control_reg <= `XIC_RST_BYTE;
    else if (wr_nonmaskable_control) nonmaskable_control_reg <= {4'h0, bus_wdata[`XIC_CFG_FIELD-1:0]};
  end

  // cross-domain transfer: counter models the slow clock handshake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_pending_reg <= 1'b0;
      sync_again_reg   <= 1'b0;
      sync_cnt_reg     <= 3'h0;
      nmi_active_reg   <= `XIC_RST_BYTE;
    end else if (!sync_pending_reg) begin
      if (wr_nonmaskable_control) begin
        sync_pending_reg <= 1'b1;
        sync_cnt_reg     <= 3'h1;
      end
    end else if (sync_done) begin
      nmi_active_reg <= nonmaskable_control_reg;
      if (sync_again_reg || wr_nonmaskable_control) begin
        sync_again_reg <= 1'b0;
        sync_cnt_reg   <= 3'h1;
      end else begin
        sync_pending_reg <= 1'b0;
        sync_cnt_reg     <= 3'h0;
      end
    end else begin
      sync_cnt_reg <= sync_cnt_reg + 3'h1;
      if (wr_nonmaskable_control) sync_again_reg <= 1'b1;
    end
  end

  // set ungated, write-one clears; set wins
  always_ff @(posedge clk) begin
    if (!rst_n) nonmaskable_pending_reg <= 1'b0;
    else if (nmi_det) nonmaskable_pending_reg <= 1'b1;
    else if (bus_wr && hit(bus_addr, `XIC_IDX_NMIPEND) && bus_wdata[`XIC_NMI_PEND_BIT])
      nonmaskable_pending_reg <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) line_event_enable_reg <= LINES'(`XIC_RST_WORD);
    else if (bus_wr && hit(bus_addr, `XIC_IDX_EVEN))
      line_event_enable_reg <= bus_wdata[LINES-1:0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_cfg_reg[0] <= `XIC_RST_WORD;
      line_cfg_reg[1] <= `XIC_RST_WORD;
    end else if (bus_wr && hit(bus_addr, `XIC_IDX_CFG0)) begin
      line_cfg_reg[0] <= bus_wdata;
    end else if (bus_wr && hit(bus_addr, `XIC_IDX_CFG1)) begin
      line_cfg_reg[1] <= bus_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_line_irq_en_reg <= LINES'(`XIC_RST_WORD);
    end else if (bus_wr && hit(bus_addr, `XIC_IDX_ENCLR)) begin
      ext_line_irq_en_reg <= ext_line_irq_en_reg & ~bus_wdata[LINES-1:0];
    end else if (bus_wr && hit(bus_addr, `XIC_IDX_ENSET)) begin
      ext_line_irq_en_reg <= ext_line_irq_en_reg | bus_wdata[LINES-1:0];
    end
  end

  // sticky flags; read clears, a new detection in that cycle survives
  always_ff @(posedge clk) begin
    if (!rst_n) line_pending_flags_reg <= LINES'(`XIC_RST_WORD);
    else if (bus_rd && hit(bus_addr, `XIC_IDX_FLAGS)) line_pending_flags_reg <= line_det;
    else line_pending_flags_reg <= line_pending_flags_reg | line_det;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) line_event_reg <= LINES'(`XIC_RST_WORD);
    else        line_event_reg <= line_det & line_event_enable_reg;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nmi_irq_reg  <= 1'b0;
      line_irq_reg <= 1'b0;
    end else begin
      nmi_irq_reg  <= nonmaskable_pending_reg;
      line_irq_reg <= |(line_pending_flags_reg & ext_line_irq_en_reg);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = `XIC_RST_WORD;
    if (hit(bus_addr, `XIC_IDX_SYNC)) begin
      rdata_next[`XIC_SYNC_BIT] = sync_pending_reg;
    end else if (hit(bus_addr, `XIC_IDX_NONMASKABLE_CONTROL)) begin
      rdata_next[7:0] = nonmaskable_control_reg;
    end else if (hit(bus_addr, `XIC_IDX_NMIPEND)) begin
      rdata_next[`XIC_NMI_PEND_BIT] = nonmaskable_pending_reg;
    end else if (hit(bus_addr, `XIC_IDX_EVEN)) begin
      rdata_next[LINES-1:0] = line_event_enable_reg;
    end else if (hit(bus_addr, `XIC_IDX_ENCLR) || hit(bus_addr, `XIC_IDX_ENSET)) begin
      rdata_next[LINES-1:0] = ext_line_irq_en_reg;
    end else if (hit(bus_addr, `XIC_IDX_FLAGS)) begin
      rdata_next[LINES-1:0] = line_pending_flags_reg;
    end else if (hit(bus_addr, `XIC_IDX_CFG0)) begin
      rdata_next = line_cfg_reg[0];
    end else if (hit(bus_addr, `XIC_IDX_CFG1)) begin
      rdata_next = line_cfg_reg[1];
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_n)      rdata_reg <= `XIC_RST_WORD;
    else if (bus_rd) rdata_reg <= rdata_next;
    else             rdata_reg <= `XIC_RST_WORD;
  end

  assign bus_rdata  = rdata_reg;
  assign line_event = line_event_reg;
  assign nmi_irq    = nmi_irq_reg;
  assign line_irq   = line_irq_reg;

  AST_SYNC_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_nonmaskable_control && !sync_pending_reg) |=> sync_pending_reg)
    else $error("sync pending not raised on transfer start");
  AST_SYNC_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_nonmaskable_control && !sync_pending_reg) ##1 (!wr_nonmaskable_control)[*3] |=> !sync_pending_reg)
    else $error("sync pending not cleared after transfer");
  AST_SYNC_QUEUE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_nonmaskable_control && sync_pending_reg) |=> sync_pending_reg ##[1:6] !sync_pending_reg
      or ##[1:6] (nmi_active_reg == nonmaskable_control_reg))
    else $error("queued control write never applied");
  AST_NMI_SET: assert property (@(posedge clk) disable iff (!rst_n)
    nmi_det |=> nonmaskable_pending_reg ##1 nmi_irq)
    else $error("nonmaskable detection lost");
  AST_NMI_W1C: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_wr && hit(bus_addr, `XIC_IDX_NMIPEND) && !bus_wdata[0] && nonmaskable_pending_reg)
      |=> nonmaskable_pending_reg)
    else $error("write of zero cleared nonmaskable flag");
  AST_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
    line_event == ($past(line_det) & $past(line_event_enable_reg)))
    else $error("line event mismatch");
  AST_ENCLR: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_wr && hit(bus_addr, `XIC_IDX_ENCLR))
      |=> (ext_line_irq_en_reg & $past(bus_wdata[LINES-1:0])) == '0)
    else $error("enable clear failed");
  AST_ENSET: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_wr && hit(bus_addr, `XIC_IDX_ENSET))
      |=> ext_line_irq_en_reg == ($past(ext_line_irq_en_reg) | $past(bus_wdata[LINES-1:0])))
    else $error("enable set failed");
  AST_ENREAD: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_rd && hit(bus_addr, `XIC_IDX_ENCLR)) |=> bus_rdata[LINES-1:0] == $past(ext_line_irq_en_reg))
    else $error("enable readback wrong");
  AST_LINE_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    line_irq == |($past(line_pending_flags_reg) & $past(ext_line_irq_en_reg)))
    else $error("line interrupt not gated by enable");

  // helper for the bounded-transfer check; touches no output
  logic [3:0] pend_quiet_reg;

  // cycles spent pending since the last control write, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_quiet_reg <= 4'h0;
    end else if (!sync_pending_reg || wr_nonmaskable_control) begin
      pend_quiet_reg <= 4'h0;
    end else if (pend_quiet_reg != 4'hF) begin
      pend_quiet_reg <= pend_quiet_reg + 4'h1;
    end
  end

  // transfer bookkeeping: idle means the detector already holds the setting
  AST_SYNC_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    !sync_pending_reg |-> nmi_active_reg == nonmaskable_control_reg)
    else $error("detector setting differs from control while idle");

  AST_SYNC_CNT: assert property (@(posedge clk) disable iff (!rst_n)
    sync_pending_reg == (sync_cnt_reg != 3'h0) && sync_cnt_reg <= `XIC_SYNC_CYCLES)
    else $error("transfer counter out of step with sync pending");

  // one queued transfer at most follows the last write
  AST_SYNC_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    pend_quiet_reg <= 4'(2 * `XIC_SYNC_CYCLES))
    else $error("sync pending outlived its transfer");

  AST_SYNC_LATE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_nonmaskable_control && sync_pending_reg && !sync_done) |=> sync_again_reg)
    else $error("control write during transfer not queued");

  AST_SYNC_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    (sync_done && (sync_again_reg || wr_nonmaskable_control))
      |=> sync_pending_reg && sync_cnt_reg == 3'h1)
    else $error("queued transfer did not restart");

  AST_CTRL_RB: assert property (@(posedge clk) disable iff (!rst_n)
    wr_nonmaskable_control |=> nonmaskable_control_reg == {4'h0, $past(bus_wdata[`XIC_CFG_FIELD-1:0])})
    else $error("control write did not complete");

  // nonmaskable flag and request
  AST_NMI_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_wr && hit(bus_addr, `XIC_IDX_NMIPEND) && bus_wdata[`XIC_NMI_PEND_BIT] && !nmi_det)
      |=> !nonmaskable_pending_reg)
    else $error("write of one left nonmaskable flag set");

  AST_NMI_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    (nonmaskable_pending_reg && !(bus_wr && hit(bus_addr, `XIC_IDX_NMIPEND)))
      |=> nonmaskable_pending_reg)
    else $error("nonmaskable flag dropped without a clear");

  AST_NMI_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    nmi_irq == $past(nonmaskable_pending_reg))
    else $error("nonmaskable interrupt does not follow its flag");

  // line enables and their readback
  AST_ENCLR_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_wr && hit(bus_addr, `XIC_IDX_ENCLR))
      |=> ext_line_irq_en_reg == ($past(ext_line_irq_en_reg) & ~$past(bus_wdata[LINES-1:0])))
    else $error("enable clear touched bits written zero");

  AST_EN_STILL: assert property (@(posedge clk) disable iff (!rst_n)
    !(bus_wr && (hit(bus_addr, `XIC_IDX_ENCLR) || hit(bus_addr, `XIC_IDX_ENSET)))
      |=> $stable(ext_line_irq_en_reg))
    else $error("line enables changed without a write");

  AST_ENSET_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_rd && hit(bus_addr, `XIC_IDX_ENSET))
      |=> bus_rdata[LINES-1:0] == $past(ext_line_irq_en_reg))
    else $error("enable readback through the set register wrong");

  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_rd |=> bus_rdata == '0)
    else $error("read data stood beyond its cycle");

  // line flags and events
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (|line_det) |=> (line_pending_flags_reg & $past(line_det)) == $past(line_det))
    else $error("line detection did not set its flag");

  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    !(bus_rd && hit(bus_addr, `XIC_IDX_FLAGS))
      |=> ($past(line_pending_flags_reg) & ~line_pending_flags_reg) == '0)
    else $error("line flag dropped without a read");

  AST_EVENT_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (line_event_enable_reg == '0) |=> line_event == '0)
    else $error("event emitted from a disabled line");

  AST_EVENT_FREE: assert property (@(posedge clk) disable iff (!rst_n)
    (|(line_det & line_event_enable_reg & ~ext_line_irq_en_reg)) |=> (|line_event))
    else $error("event held back by the interrupt enable");
endmodule // xic_ctrl

// File: test/xic_pin_model.sv
// stand-in for the external pins and the event system
module xic_pin_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        nmi_req,
  input  wire logic [15:0] line_req,
  input  wire logic [15:0] line_event,
  output logic             nonmaskable_pin = 1'b0,
  output logic [15:0]      ext_line_pin = 16'h0000,
  output int               event_count = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins move just after the edge, like any off-chip source
  always @(posedge clk) begin
    nonmaskable_pin <= nmi_req;
    ext_line_pin    <= line_req;
  end
  // counts pulses per cycle: a level event would over-count
  always @(posedge clk) begin
    if (!rst_n)
      event_count <= 0;
    else
      event_count <= event_count + $countones(line_event);
  end
endmodule // xic_pin_model

// File: test/xic_ctrl_tb.sv
// self-checking bench of the interrupt control registers
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("ERROR at %0t: got %h expected %h", $time, (a), (e)); end end
module xic_ctrl_tb
  import xic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_SYN = 8'h01, A_NC = 8'h02, A_NP = 8'h03, A_EV = 8'h04;
  localparam logic [7:0] A_CLR = 8'h08, A_SET = 8'h0C, A_FLG = 8'h10;
  localparam logic [7:0] A_CF0 = 8'h18, A_CF1 = 8'h1C;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic        nmi_req = 1'b0;
  logic [15:0] line_req = 16'h0000;
  logic [31:0] bus_rdata, rdv;
  logic        nonmaskable_pin, nmi_irq, line_irq;
  logic [15:0] ext_line_pin, line_event;
  int          event_count;
  int          failures = 0;
  int          n_compared = 0;

  always #50 clk = ~clk;

  xic_ctrl #(.LINES(16)) dut (
    .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .nonmaskable_pin(nonmaskable_pin), .ext_line_pin(ext_line_pin),
    .line_event(line_event), .nmi_irq(nmi_irq), .line_irq(line_irq));
  xic_pin_model pm (
    .clk(clk), .rst_n(rst_n), .nmi_req(nmi_req), .line_req(line_req),
    .line_event(line_event), .nonmaskable_pin(nonmaskable_pin),
    .ext_line_pin(ext_line_pin), .event_count(event_count));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1 rdv = bus_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rdv, e)
  endtask
  // outputs are read one step after the edge, once its updates landed
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded poll: a stuck pending bit ends as a mismatch, not a hang
  task automatic sync_wait();
    int k = 0;
    rd(A_SYN);
    while (rdv !== 32'h0000_0000 && k < 20) begin
      rd(A_SYN);
      k++;
    end
    `CHK(rdv, 32'h0000_0000)
  endtask

  task automatic t_reset();
    logic [7:0] am [11] = '{A_SYN, A_NC, A_NP, A_EV, A_CLR, A_SET, A_FLG, A_CF0, A_CF1,
                            8'h00, 8'h3C};
    wr(8'h3C, 32'hFFFF_FFFF);
    foreach (am[i]) rc(am[i], 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_sync();
    wr(A_NC, 32'h0000_0001);
    rc(A_SYN, 32'h0000_0080);
    rc(A_SYN, 32'h0000_0000);
    wr(A_NC, 32'h0000_0004);
    wr(A_NC, 32'h0000_00FB);
    rc(A_SYN, 32'h0000_0080);
    rc(A_NC, 32'h0000_000B);
    sync_wait();
    $display("test sync done");
  endtask

  // clear flag, move pin (or pulse it for one cycle), then judge flag and irq
  task automatic ph(input logic lvl, input logic gl, input logic e);
    wr(A_NP, 32'h0000_0001);
    nmi_req <= lvl;
    if (gl) begin
      @(posedge clk);
      nmi_req <= 1'b0;
    end
    idle(12);
    rc(A_NP, {31'h0000_0000, e});
    `CHK(nmi_irq, e)
  endtask

  task automatic t_nmi();
    logic ea, eb, ec, ed;
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 8; c++) begin
        ea = (c == XIC_LOW);
        eb = c inside {XIC_RISE, XIC_BOTH, XIC_HIGH, XIC_LOW};
        ec = c inside {XIC_FALL, XIC_BOTH, XIC_HIGH, XIC_LOW};
        ed = f ? ea : (c inside {[1:5]});
        wr(A_NC, {28'h000_0000, f[0], c[2:0]});
        sync_wait();
        ph(1'b0, 1'b0, ea);
        ph(1'b1, 1'b0, eb);
        wr(A_NP, 32'h0000_0000);
        rc(A_NP, {31'h0000_0000, eb});
        ph(1'b0, 1'b0, ec);
        ph(1'b1, 1'b1, ed);
      end
    end
    $display("test nonmaskable done");
  endtask

  task automatic t_enables();
    wr(A_EV, 32'hFFFF_FFFF);
    rc(A_EV, 32'h0000_FFFF);
    wr(A_SET, 32'hFFFF_00F0);
    wr(A_SET, 32'h0000_000F);
    rc(A_CLR, 32'h0000_00FF);
    wr(A_CLR, 32'h0000_0030);
    wr(A_SET, 32'h0000_0000);
    wr(A_CLR, 32'h0000_0000);
    rc(A_SET, 32'h0000_00CF);
    @(posedge clk);
    #1 `CHK(bus_rdata, 32'h0000_0000)
    $display("test enables done");
  endtask

  task automatic t_lines();
    int base;
    wr(A_CLR, 32'h0000_FFFF);
    wr(A_EV, 32'h0000_8001);
    wr(A_SET, 32'h0000_0002);
    wr(A_CF0, 32'h0000_0011);
    wr(A_CF1, 32'h1000_0000);
    idle(12);
    rc(A_FLG, 32'h0000_0000);
    base = event_count;
    @(posedge clk);
    line_req <= 16'h8001;
    idle(12);
    `CHK(line_irq, 1'b0)
    `CHK(event_count - base, 2)
    @(posedge clk);
    line_req <= 16'h8003;
    idle(12);
    `CHK(line_irq, 1'b1)
    `CHK(event_count - base, 2)
    wr(A_CLR, 32'h0000_0002);
    idle(2);
    `CHK(line_irq, 1'b0)
    rc(A_FLG, 32'h0000_8003);
    rc(A_FLG, 32'h0000_0000);
    $display("test lines done");
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_sync();
    t_nmi();
    t_enables();
    t_lines();
    print_verdict();
  end
  // about twenty times the expected run length
  initial begin
    #(30_000 * 100);
    failures++;
    print_verdict();
  end
endmodule // xic_ctrl_tb
